// [design/icgc_pkg.sv]
// Purpose: shared constants and types for the clock generator core
// Assumes: 25 MHz system clock, 8-bit register port
// Notes: thresholds are base clock periods counted in system cycles
package icgc_pkg;

    // register port
    localparam int ADDR_W = 4;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_CTRL = 4'h0;
    localparam logic [ADDR_W-1:0] ADDR_MULT = 4'h1;
    localparam logic [ADDR_W-1:0] ADDR_CFG = 4'h2;
    localparam logic [ADDR_W-1:0] ADDR_STAT = 4'h3;
    localparam logic [ADDR_W-1:0] ADDR_DIVC = 4'h4;
    localparam logic [ADDR_W-1:0] ADDR_STGC = 4'h5;

    // control register fields
    localparam int CTRL_INT_ON = 0;
    localparam int CTRL_EXT_ON = 1;
    localparam int CTRL_SRC_EXT = 2;
    // configuration register fields
    localparam int CFG_RUN_STOP = 0;
    localparam int CFG_EXT_OK = 1;
    localparam int CFG_XTAL_OK = 2;
    // status register fields
    localparam int STAT_STABLE = 0;
    localparam int STAT_INT_EN = 1;
    localparam int STAT_EXT_EN = 2;
    localparam int STAT_STOP = 3;
    localparam int STAT_VALID = 4;

    // reset values
    localparam logic [DATA_W-1:0] CTRL_RST = 8'h01;
    localparam logic [DATA_W-1:0] MULT_RST = 8'h01;
    localparam logic [DATA_W-1:0] CFG_RST = 8'h00;
    localparam logic [11:0] LOOP_RST = 12'h9ff;

    // loop value limits and corrections
    localparam logic [11:0] LOOP_MAX_VALID = 12'h9ff;
    localparam logic [11:0] LOOP_TOP = 12'hfff;
    localparam logic [3:0] DIV_SLOWEST = 4'h9;
    localparam logic [11:0] CORR_FINE = 12'h001;
    localparam logic [11:0] CORR_MID = 12'h008;
    localparam logic [11:0] CORR_COARSE = 12'h020;

    // oscillator phase step: step = top - value * scale
    localparam logic [16:0] DCO_STEP_TOP = 17'h10000;
    localparam logic [16:0] DCO_STEP_SCALE = 17'h00019;

    // frequencies
    localparam longint CLK_FREQ_HZ = 25000000;
    localparam longint NOM_FREQ_DHZ = 3072000; // 307.2 kHz in 0.1 Hz
    localparam longint BUS_STEP_DHZ = 768000; // 76.8 kHz in 0.1 Hz

    // period counter and band thresholds (cycles per base period)
    localparam int PER_W = 10;
    localparam logic [PER_W-1:0] PER_MAX = 10'h3ff;
    localparam logic [PER_W-1:0] PER_ONE = 10'h001;
    localparam logic [PER_W-1:0] CMP_TH85 =
        PER_W'((CLK_FREQ_HZ * 1000) / (NOM_FREQ_DHZ * 85));
    localparam logic [PER_W-1:0] CMP_TH95 =
        PER_W'((CLK_FREQ_HZ * 1000) / (NOM_FREQ_DHZ * 95));
    localparam logic [PER_W-1:0] CMP_TH100 =
        PER_W'((CLK_FREQ_HZ * 1000) / (NOM_FREQ_DHZ * 100));
    localparam logic [PER_W-1:0] CMP_TH105 =
        PER_W'((CLK_FREQ_HZ * 1000) / (NOM_FREQ_DHZ * 105));
    localparam logic [PER_W-1:0] CMP_TH115 =
        PER_W'((CLK_FREQ_HZ * 1000) / (NOM_FREQ_DHZ * 115));

    // error band, named by the correction it asks for
    typedef enum logic [5:0] {
        BAND_SUB32 = 6'b000001,
        BAND_SUB8 = 6'b000010,
        BAND_SUB1 = 6'b000100,
        BAND_ADD1 = 6'b001000,
        BAND_ADD8 = 6'b010000,
        BAND_ADD32 = 6'b100000
    } icgc_band_e;

endpackage

// [design/icgc_cmp_if.sv]
// Purpose: link between loop filter and frequency comparator
// Assumes: one clock domain
// Notes: valid is a one-cycle pulse per completed base period
`timescale 1ns/10ps
interface icgc_cmp_if;
    import icgc_pkg::*;
    logic base;
    logic enable;
    logic valid;
    icgc_band_e band;
    modport meas (input base, input enable, output valid, output band);
    modport filt (output base, output enable, input valid, input band);
endinterface

// [design/icgc_freq_cmp.sv]
// Purpose: measure base clock period and classify its error band
// Assumes: base is a level from a flop on the same clock
// Notes: first edge after enable only starts a measurement
`timescale 1ns/10ps
module icgc_freq_cmp (
    input wire logic clk_in,
    input wire logic resetn_in,
    icgc_cmp_if.meas cmp
);
    import icgc_pkg::*;

    logic base_d_r;
    logic seen_r;
    logic [PER_W-1:0] per_r;
    logic valid_r;
    icgc_band_e band_r;
    icgc_band_e band_nxt;
    logic rise;

    assign rise = cmp.base & ~base_d_r;
    assign cmp.valid = valid_r;
    assign cmp.band = band_r;

    // period compared against nominal thresholds
    always_comb begin
        if (per_r > CMP_TH85) begin
            band_nxt = BAND_SUB32;
        end else if (per_r > CMP_TH95) begin
            band_nxt = BAND_SUB8;
        end else if (per_r > CMP_TH100) begin
            band_nxt = BAND_SUB1;
        end else if (per_r > CMP_TH105) begin
            band_nxt = BAND_ADD1;
        end else if (per_r > CMP_TH115) begin
            band_nxt = BAND_ADD8;
        end else begin
            band_nxt = BAND_ADD32;
        end
    end

    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            base_d_r <= 1'b0;
            seen_r <= 1'b0;
            per_r <= '0;
            valid_r <= 1'b0;
            band_r <= BAND_ADD1;
        end else if (!cmp.enable) begin
            base_d_r <= 1'b0;
            seen_r <= 1'b0;
            per_r <= '0;
            valid_r <= 1'b0;
        end else begin
            base_d_r <= cmp.base;
            valid_r <= rise & seen_r;
            if (rise) begin
                seen_r <= 1'b1;
                per_r <= PER_ONE;
                if (seen_r) begin
                    band_r <= band_nxt;
                end
            end else if (per_r != PER_MAX) begin
                per_r <= per_r + PER_ONE;
            end
        end
    end

endmodule // icgc_freq_cmp

// [design/icgc_core.sv]
// Purpose: enable, internal generation and selection of generator clocks
// Assumes: single 25 MHz clock; clock outputs are flop levels
// Notes: registers reached over a plain strobe port
// Behaviour
// - bus clock is a quarter of oscillator clock, half of generator clock
// - stop mode with run-in-stop clear asserts generator stop
// - run-in-stop set keeps clocks running and stop deasserted
// - internal enable equals internal on bit and not stop
// - internal enable off holds internal and base clocks low
// - external enable equals external on bit and not stop; clock low else
// - external on bit cannot be set unless external clock allowed
// - oscillator input port disabled whenever external on bit set
// - oscillator output port disabled when external on and crystal allowed
// - base clock is internal clock divided by multiplier factor
// - multiplier of zero or one passes internal clock straight through
// - oscillator period set by eight-bit stage and four-bit divider fields
// - loop value valid only from zero to 9FF
// - stable base clock regulated to 307.2 kHz nominal
// - base clock compared with nominal, result feeds loop filter
// - software selects internal or external bus source, 76.8 kHz steps
// - timebase clock taken from external clock whenever available
// - filter adds or subtracts 1, 8 or 32 by error band
// - stable flag set when error under five percent
// - divider field A to F acts as nine, the slowest
//
// Our own choices: the placing of the registers and the plain strobed port.
`timescale 1ns/10ps
module icgc_core (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic [icgc_pkg::ADDR_W-1:0] ADDR_IN,
    input wire logic [icgc_pkg::DATA_W-1:0] WDATA_IN,
    input wire logic WR_IN,
    input wire logic RD_IN,
    output logic [icgc_pkg::DATA_W-1:0] RDATA_OUT,
    input wire logic STOP_MODE_IN,
    input wire logic EXT_CLK_PIN_IN,
    output logic GEN_STOP_OUT,
    output logic INT_GEN_EN_OUT,
    output logic EXT_GEN_EN_OUT,
    output logic OSC_IN_PORT_EN_OUT,
    output logic OSC_OUT_PORT_EN_OUT,
    output logic INT_CLK_OUT,
    output logic EXT_CLK_OUT,
    output logic BASE_CLK_OUT,
    output logic OSC_OUT_CLK_OUT,
    output logic GEN_OUT_CLK_OUT,
    output logic BUS_CLK_OUT,
    output logic TIMEBASE_CLK_OUT,
    output logic FILTER_STABLE_OUT,
    output logic [3:0] DIV_CTRL_OUT,
    output logic [7:0] STAGE_CTRL_OUT
);
    import icgc_pkg::*;

    // software state
    logic int_on_r;
    logic ext_on_r;
    logic src_ext_r;
    logic [DATA_W-1:0] mult_r;
    logic run_stop_r;
    logic ext_ok_r;
    logic xtal_ok_r;
    logic [DATA_W-1:0] rdata_r;
    logic [DATA_W-1:0] rd_mux;

    // enables
    logic gen_stop_r;
    logic gen_stop_nxt;
    logic int_en_r;
    logic ext_en_r;
    logic in_port_en_r;
    logic out_port_en_r;

    // oscillator and divider
    logic [11:0] loop_r;
    logic [11:0] loop_nxt;
    logic [3:0] div_eff;
    logic [11:0] loop_eff;
    logic [16:0] step;
    logic [16:0] acc_r;
    logic [17:0] acc_sum;
    logic internal_clock_r;
    logic internal_clock_nxt;
    logic internal_clock_rise;
    logic [DATA_W-1:0] div_cnt_r;
    logic [DATA_W-1:0] div_cnt_nxt;
    logic base_r;
    logic stable_r;
    logic loop_valid_r;

    // external path and selection
    logic ext_s1_r;
    logic ext_s2_r;
    logic external_clock_r;
    logic osc_r;
    logic osc_sel;
    logic osc_rise;
    logic gen_r;
    logic gen_rise;
    logic bus_r;
    logic tb_r;

    icgc_cmp_if cmp ();

    icgc_freq_cmp u_cmp (
        .clk_in(CLK_IN),
        .resetn_in(RESETN_IN),
        .cmp(cmp.meas)
    );

    assign cmp.base = base_r;
    assign cmp.enable = int_en_r;

    // control register writes
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            int_on_r <= CTRL_RST[CTRL_INT_ON];
            ext_on_r <= CTRL_RST[CTRL_EXT_ON];
            src_ext_r <= CTRL_RST[CTRL_SRC_EXT];
        end else if (WR_IN && ADDR_IN == ADDR_CTRL) begin
            int_on_r <= WDATA_IN[CTRL_INT_ON];
            ext_on_r <= WDATA_IN[CTRL_EXT_ON] & ext_ok_r;
            src_ext_r <= WDATA_IN[CTRL_SRC_EXT];
        end
    end

    // multiplier register
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            mult_r <= MULT_RST;
        end else if (WR_IN && ADDR_IN == ADDR_MULT) begin
            mult_r <= WDATA_IN;
        end
    end

    // configuration register
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            run_stop_r <= CFG_RST[CFG_RUN_STOP];
            ext_ok_r <= CFG_RST[CFG_EXT_OK];
            xtal_ok_r <= CFG_RST[CFG_XTAL_OK];
        end else if (WR_IN && ADDR_IN == ADDR_CFG) begin
            run_stop_r <= WDATA_IN[CFG_RUN_STOP];
            ext_ok_r <= WDATA_IN[CFG_EXT_OK];
            xtal_ok_r <= WDATA_IN[CFG_XTAL_OK];
        end
    end

    // read data, valid only in the cycle after the strobe
    always_comb begin
        rd_mux = '0;
        case (ADDR_IN)
            ADDR_CTRL: begin
                rd_mux[CTRL_INT_ON] = int_on_r;
                rd_mux[CTRL_EXT_ON] = ext_on_r;
                rd_mux[CTRL_SRC_EXT] = src_ext_r;
            end
            ADDR_MULT: begin
                rd_mux = mult_r;
            end
            ADDR_CFG: begin
                rd_mux[CFG_RUN_STOP] = run_stop_r;
                rd_mux[CFG_EXT_OK] = ext_ok_r;
                rd_mux[CFG_XTAL_OK] = xtal_ok_r;
            end
            ADDR_STAT: begin
                rd_mux[STAT_STABLE] = stable_r;
                rd_mux[STAT_INT_EN] = int_en_r;
                rd_mux[STAT_EXT_EN] = ext_en_r;
                rd_mux[STAT_STOP] = gen_stop_r;
                rd_mux[STAT_VALID] = loop_valid_r;
            end
            ADDR_DIVC: begin
                rd_mux[3:0] = loop_r[11:8];
            end
            ADDR_STGC: begin
                rd_mux = loop_r[7:0];
            end
            default: begin
                rd_mux = '0;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            rdata_r <= '0;
        end else if (RD_IN) begin
            rdata_r <= rd_mux;
        end else begin
            rdata_r <= '0;
        end
    end

    // stop and generator enables
    assign gen_stop_nxt = STOP_MODE_IN & ~run_stop_r;

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            gen_stop_r <= 1'b0;
            int_en_r <= 1'b0;
            ext_en_r <= 1'b0;
        end else begin
            gen_stop_r <= gen_stop_nxt;
            int_en_r <= int_on_r & ~gen_stop_nxt;
            ext_en_r <= ext_on_r & ~gen_stop_nxt;
        end
    end

    // port enables ignore stop
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            in_port_en_r <= 1'b1;
            out_port_en_r <= 1'b1;
        end else begin
            in_port_en_r <= ~ext_on_r;
            out_port_en_r <= ~(ext_on_r & xtal_ok_r);
        end
    end

    // oscillator period from divider and stage fields
    assign div_eff = (loop_r[11:8] > DIV_SLOWEST) ?
        DIV_SLOWEST : loop_r[11:8];
    assign loop_eff = {div_eff, loop_r[7:0]};
    assign step = DCO_STEP_TOP - 17'(17'(loop_eff) * DCO_STEP_SCALE);
    assign acc_sum = {1'b0, acc_r} + {1'b0, step};
    assign internal_clock_nxt = acc_sum[17] ? ~internal_clock_r : internal_clock_r;
    assign internal_clock_rise = acc_sum[17] & ~internal_clock_r;

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            acc_r <= '0;
            internal_clock_r <= 1'b0;
        end else if (!int_en_r) begin
            acc_r <= '0;
            internal_clock_r <= 1'b0;
        end else begin
            acc_r <= acc_sum[16:0];
            internal_clock_r <= internal_clock_nxt;
        end
    end

    // modulo n divider
    assign div_cnt_nxt = (div_cnt_r >= mult_r - 8'h01) ?
        8'h00 : div_cnt_r + 8'h01;

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            div_cnt_r <= '0;
            base_r <= 1'b0;
        end else if (!int_en_r) begin
            div_cnt_r <= '0;
            base_r <= 1'b0;
        end else if (mult_r <= 8'h01) begin
            div_cnt_r <= '0;
            base_r <= internal_clock_nxt;
        end else if (internal_clock_rise) begin
            div_cnt_r <= div_cnt_nxt;
            base_r <= div_cnt_nxt < (mult_r >> 1);
        end
    end

    // loop filter, one correction per comparison
    always_comb begin
        loop_nxt = loop_r;
        case (cmp.band)
            BAND_SUB32: begin
                loop_nxt = (loop_r < CORR_COARSE) ?
                    12'h000 : loop_r - CORR_COARSE;
            end
            BAND_SUB8: begin
                loop_nxt = (loop_r < CORR_MID) ?
                    12'h000 : loop_r - CORR_MID;
            end
            BAND_SUB1: begin
                loop_nxt = (loop_r < CORR_FINE) ?
                    12'h000 : loop_r - CORR_FINE;
            end
            BAND_ADD1: begin
                loop_nxt = (loop_r > LOOP_TOP - CORR_FINE) ?
                    LOOP_TOP : loop_r + CORR_FINE;
            end
            BAND_ADD8: begin
                loop_nxt = (loop_r > LOOP_TOP - CORR_MID) ?
                    LOOP_TOP : loop_r + CORR_MID;
            end
            BAND_ADD32: begin
                loop_nxt = (loop_r > LOOP_TOP - CORR_COARSE) ?
                    LOOP_TOP : loop_r + CORR_COARSE;
            end
            default: begin
                loop_nxt = loop_r;
            end
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            loop_r <= LOOP_RST;
        end else if (cmp.valid) begin
            loop_r <= loop_nxt;
        end
    end

    // stable flag and range check
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            stable_r <= 1'b0;
        end else if (!int_en_r) begin
            stable_r <= 1'b0;
        end else if (cmp.valid) begin
            stable_r <= (cmp.band == BAND_SUB1) ||
                (cmp.band == BAND_ADD1);
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            loop_valid_r <= 1'b1;
        end else begin
            loop_valid_r <= loop_r <= LOOP_MAX_VALID;
        end
    end

    // external clock pin synchroniser
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            ext_s1_r <= 1'b0;
            ext_s2_r <= 1'b0;
        end else begin
            ext_s1_r <= EXT_CLK_PIN_IN;
            ext_s2_r <= ext_s1_r;
        end
    end

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            external_clock_r <= 1'b0;
        end else begin
            external_clock_r <= ext_s2_r & ext_en_r;
        end
    end

    // source select and bus dividers
    assign osc_sel = (src_ext_r && ext_en_r) ? external_clock_r : internal_clock_r;
    assign osc_rise = osc_sel & ~osc_r;
    assign gen_rise = osc_rise & ~gen_r;

    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            osc_r <= 1'b0;
            gen_r <= 1'b0;
            bus_r <= 1'b0;
        end else begin
            osc_r <= osc_sel;
            if (osc_rise) begin
                gen_r <= ~gen_r;
            end
            if (gen_rise) begin
                bus_r <= ~bus_r;
            end
        end
    end

    // timebase source
    always_ff @(posedge CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
            tb_r <= 1'b0;
        end else begin
            tb_r <= ext_en_r ? external_clock_r : internal_clock_r;
        end
    end

    assign RDATA_OUT = rdata_r;
    assign GEN_STOP_OUT = gen_stop_r;
    assign INT_GEN_EN_OUT = int_en_r;
    assign EXT_GEN_EN_OUT = ext_en_r;
    assign OSC_IN_PORT_EN_OUT = in_port_en_r;
    assign OSC_OUT_PORT_EN_OUT = out_port_en_r;
    assign INT_CLK_OUT = internal_clock_r;
    assign EXT_CLK_OUT = external_clock_r;
    assign BASE_CLK_OUT = base_r;
    assign OSC_OUT_CLK_OUT = osc_r;
    assign GEN_OUT_CLK_OUT = gen_r;
    assign BUS_CLK_OUT = bus_r;
    assign TIMEBASE_CLK_OUT = tb_r;
    assign FILTER_STABLE_OUT = stable_r;
    assign DIV_CTRL_OUT = loop_r[11:8];
    assign STAGE_CTRL_OUT = loop_r[7:0];

endmodule // icgc_core

// [sim/icgc_core_checker.sv]
// Purpose: port assertions for the clock generator core
// Assumes: one clock domain, async active-low reset
// Notes: bound to every core instance
`timescale 1ns/10ps
module icgc_core_checker (
    input wire logic CLK_IN,
    input wire logic RESETN_IN,
    input wire logic STOP_MODE_IN,
    input wire logic GEN_STOP_OUT,
    input wire logic INT_GEN_EN_OUT,
    input wire logic EXT_GEN_EN_OUT,
    input wire logic OSC_IN_PORT_EN_OUT,
    input wire logic OSC_OUT_PORT_EN_OUT,
    input wire logic INT_CLK_OUT,
    input wire logic EXT_CLK_OUT,
    input wire logic BASE_CLK_OUT,
    input wire logic FILTER_STABLE_OUT,
    input wire logic [3:0] DIV_CTRL_OUT,
    input wire logic [7:0] STAGE_CTRL_OUT
);
    wire logic [11:0] loop_v = {DIV_CTRL_OUT, STAGE_CTRL_OUT};
    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESETN_IN);

    chk_stop_cause: assert property (
        !STOP_MODE_IN |=> !GEN_STOP_OUT) else $error("stop without request");
    chk_stop_gates: assert property (
        GEN_STOP_OUT |-> !INT_GEN_EN_OUT && !EXT_GEN_EN_OUT)
        else $error("enable active in stop");
    chk_int_low: assert property (
        (!INT_GEN_EN_OUT)[*2] |-> !INT_CLK_OUT && !BASE_CLK_OUT)
        else $error("internal clocks run while disabled");
    chk_ext_low: assert property (
        (!EXT_GEN_EN_OUT)[*2] |-> !EXT_CLK_OUT)
        else $error("external clock runs while disabled");
    chk_in_port: assert property (
        EXT_GEN_EN_OUT |-> !OSC_IN_PORT_EN_OUT)
        else $error("input pin port enabled");
    chk_out_port: assert property (
        !OSC_OUT_PORT_EN_OUT |-> !OSC_IN_PORT_EN_OUT)
        else $error("output pin freed without ext on");
    chk_loop_step: assert property (
        $changed(loop_v) |-> (12'(loop_v - $past(loop_v)) inside
        {12'h001, 12'h008, 12'h020, 12'hfff, 12'hff8, 12'hfe0})
        || loop_v inside {12'h000, 12'hfff}) else $error("bad step");
    chk_loop_hold: assert property (
        $changed(loop_v) |=> $stable(loop_v)) else $error("double step");
    chk_stable_clr: assert property (
        (!INT_GEN_EN_OUT)[*3] |-> !FILTER_STABLE_OUT)
        else $error("stable while generator off");

    cover property ($rose(GEN_STOP_OUT));
    cover property ($rose(FILTER_STABLE_OUT));
    cover property ($rose(EXT_GEN_EN_OUT));
endmodule // icgc_core_checker

bind icgc_core icgc_core_checker u_chk (.CLK_IN, .RESETN_IN, .STOP_MODE_IN,
    .GEN_STOP_OUT, .INT_GEN_EN_OUT, .EXT_GEN_EN_OUT, .OSC_IN_PORT_EN_OUT,
    .OSC_OUT_PORT_EN_OUT, .INT_CLK_OUT, .EXT_CLK_OUT, .BASE_CLK_OUT,
    .FILTER_STABLE_OUT, .DIV_CTRL_OUT, .STAGE_CTRL_OUT);

// [sim/icgc_sys_model.sv]
// Purpose: clock consumers and external clock source
// Assumes: consumed clocks are flop levels on the system clock
// Notes: counts rising edges of each clock until cleared
`timescale 1ns/10ps
module icgc_sys_model (
    input wire logic clk_in,
    input wire logic resetn_in,
    input wire logic clr_in,
    input wire logic [6:0] clks_in,
    output int cnt_out [7],
    output logic ext_pin_out
);
    logic [6:0] prev_r;
    // free-running source, unrelated in phase
    initial begin
        ext_pin_out = 1'b0;
        forever #103 ext_pin_out = ~ext_pin_out;
    end
    always_ff @(posedge clk_in or negedge resetn_in) begin
        if (!resetn_in)
            prev_r <= '0;
        else
            prev_r <= clks_in;
    end
    always_ff @(posedge clk_in) begin
        for (int i = 0; i < 7; i++) begin
            if (clr_in)
                cnt_out[i] <= 0;
            else if (clks_in[i] && !prev_r[i])
                cnt_out[i] <= cnt_out[i] + 1;
        end
    end
endmodule // icgc_sys_model

// [sim/icgc_core_tb_top.sv]
// Purpose: self-checking bench for the clock generator core
// Assumes: 25 MHz clock, register reads answered next cycle
// Notes: read results checked from a queue by a monitor
`timescale 1ns/10ps
module icgc_core_tb_top;
    import icgc_pkg::*;
    logic clk, resetn, wr, rd, stop_mode, clr;
    logic rd_q = 1'b0;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata, rdata;
    logic gen_stop, int_en, ext_en, in_en, out_en, stable, ext_pin;
    logic int_clk, ext_clk, base_clk, osc_clk, gen_clk, bus_clk, tb_clk;
    logic [3:0] div_c;
    logic [7:0] stg_c;
    int cnt [7];
    int n_mismatch = 0;
    int checks_done = 0;
    logic [7:0] exp_q [$];
    logic [31:0] seed = 32'h144be9f9;

    icgc_core dut (.CLK_IN(clk), .RESETN_IN(resetn), .ADDR_IN(addr),
        .WDATA_IN(wdata), .WR_IN(wr), .RD_IN(rd), .RDATA_OUT(rdata),
        .STOP_MODE_IN(stop_mode), .EXT_CLK_PIN_IN(ext_pin),
        .GEN_STOP_OUT(gen_stop), .INT_GEN_EN_OUT(int_en),
        .EXT_GEN_EN_OUT(ext_en), .OSC_IN_PORT_EN_OUT(in_en),
        .OSC_OUT_PORT_EN_OUT(out_en), .INT_CLK_OUT(int_clk),
        .EXT_CLK_OUT(ext_clk), .BASE_CLK_OUT(base_clk),
        .OSC_OUT_CLK_OUT(osc_clk), .GEN_OUT_CLK_OUT(gen_clk),
        .BUS_CLK_OUT(bus_clk), .TIMEBASE_CLK_OUT(tb_clk),
        .FILTER_STABLE_OUT(stable), .DIV_CTRL_OUT(div_c),
        .STAGE_CTRL_OUT(stg_c));
    icgc_sys_model u_sys (.clk_in(clk), .resetn_in(resetn), .clr_in(clr),
        .clks_in({tb_clk, ext_clk, base_clk, int_clk, bus_clk, gen_clk,
        osc_clk}), .cnt_out(cnt), .ext_pin_out(ext_pin));

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("MISMATCH %0t seen %h want %h", $time, seen, exp);
        end
    endtask
    task automatic near(input int a, input int b, input int tol);
        check(12'(a > b + tol || b > a + tol), 12'h000);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        tick(1);
        wr <= 1'b0;
        tick(1);
    endtask
    task automatic rd_reg(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        addr <= a;
        rd <= 1'b1;
        tick(1);
        rd <= 1'b0;
        tick(1);
    endtask
    task automatic count(input int n);
        clr <= 1'b1;
        tick(1);
        clr <= 1'b0;
        tick(n);
    endtask
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (rd_q)
            check(rdata, exp_q.pop_front());
        rd_q <= rd;
    end

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        #(40 * 60000);
        n_mismatch++;
        end_of_test();
    end

    initial begin
        logic [3:0] ua;
        logic [7:0] nm;
        logic diff;
        int w;
        {resetn, wr, rd, stop_mode, clr} = '0;
        addr = '0;
        wdata = '0;
        tick(8);
        resetn <= 1'b1;
        check(in_en & out_en, 1);
        rd_reg(ADDR_CTRL, CTRL_RST);
        rd_reg(ADDR_MULT, MULT_RST);
        rd_reg(ADDR_CFG, CFG_RST);
        rd_reg(ADDR_DIVC, 8'(LOOP_RST[11:8]));
        rd_reg(ADDR_STGC, LOOP_RST[7:0]);
        ua = 4'h6 + 4'(rnd() % 10);
        wr_reg(ua, 8'(rnd()));
        rd_reg(ua, 8'h00);
        wr_reg(ADDR_DIVC, 8'(rnd()));
        rd_reg(ADDR_DIVC, 8'(LOOP_RST[11:8]));
        // ext on refused until allowed
        wr_reg(ADDR_CTRL, 8'h03);
        rd_reg(ADDR_CTRL, 8'h01);
        wr_reg(ADDR_CFG, 8'h02);
        wr_reg(ADDR_CTRL, 8'h03);
        rd_reg(ADDR_CTRL, 8'h03);
        check({in_en, out_en, ext_en}, 3'b011);
        wr_reg(ADDR_CFG, 8'h06);
        tick(1);
        check(out_en, 0);
        // stop with run-in-stop clear
        stop_mode <= 1'b1;
        tick(3);
        check({gen_stop, int_en, ext_en, in_en}, 4'b1000);
        rd_reg(ADDR_STAT, 8'h18);
        tick(20);
        check({int_clk, base_clk, ext_clk}, 3'b000);
        wr_reg(ADDR_CFG, 8'h07);
        tick(2);
        rd_reg(ADDR_STAT, 8'h16);
        stop_mode <= 1'b0;
        count(400);
        near(cnt[6], cnt[5], 1);
        wr_reg(ADDR_CTRL, 8'h07);
        count(400);
        near(cnt[0], cnt[5], 2);
        near(cnt[0], 4 * cnt[2], 4);
        near(cnt[1], 2 * cnt[2], 2);
        wr_reg(ADDR_CTRL, 8'h01);
        tick(3);
        check({in_en, out_en, ext_en}, 3'b110);
        // divider bypass for zero and one
        for (int m = 0; m < 2; m++) begin
            wr_reg(ADDR_MULT, 8'(m));
            diff = 1'b0;
            repeat (300) begin
                tick(1);
                diff |= (base_clk !== int_clk);
            end
            check(diff, 0);
        end
        nm = 8'(2 + rnd() % 4);
        wr_reg(ADDR_MULT, nm);
        tick(4);
        count(2000);
        near(cnt[3], int'(nm) * cnt[4], int'(nm));
        w = 0;
        while (stable !== 1'b1 && w < 40000) begin
            tick(1);
            w++;
        end
        check(stable, 1);
        count(4000);
        near(cnt[4] * int'(CMP_TH100), 4000, 400);
        // second reset in mid-run
        resetn <= 1'b0;
        tick(2);
        check({div_c, stg_c}, LOOP_RST);
        check(stable, 0);
        resetn <= 1'b1;
        tick(4);
        end_of_test();
    end
endmodule // icgc_core_tb_top
